// ### src/acrs_pkg.sv
// package: register map, field layout and codes of the converter clock and reference select block
package acrs_pkg;
  // register byte offsets on the bus
  localparam logic [11:0] CLK_DIV_OFFSET = 12'h000;
  localparam logic [11:0] REF_SEL_OFFSET = 12'h004;
  localparam logic [11:0] PCH_SEL_OFFSET = 12'h008;
  localparam int ADDR_WIDTH = 12;
  // field positions and widths
  localparam int CLK_CODE_WIDTH = 6;
  localparam int CHAN_CODE_WIDTH = 6;
  localparam int NREF_BIT = 4;
  localparam int PREF_LSB = 0;
  localparam int PREF_WIDTH = 2;
  // reset values
  localparam logic [7:0] CLK_DIV_RESET = 8'h00;
  localparam logic [7:0] REF_SEL_RESET = 8'h00;
  localparam logic [7:0] PCH_SEL_RESET = 8'h00;
  // implemented bits of the reference register
  localparam logic [7:0] REF_SEL_MASK = 8'h13;
  // positive reference codes
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_RESERVED = 2'h1;
  localparam logic [1:0] PREF_PIN = 2'h2;
  localparam logic [1:0] PREF_FIXED = 2'h3;
  // internal channel codes at the top of the channel space
  localparam logic [5:0] CHAN_FIXED_REF = 6'h3f;
  localparam logic [5:0] CHAN_DAC = 6'h3e;
  localparam logic [5:0] CHAN_TEMP = 6'h3d;
  localparam logic [5:0] CHAN_GROUND = 6'h3c;
  localparam logic [5:0] CHAN_NONE = 6'h3b;
  // ahb transfer type codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    ACRS_SRC_PIN, ACRS_SRC_NONE, ACRS_SRC_GROUND, ACRS_SRC_TEMP, ACRS_SRC_DAC, ACRS_SRC_FIXED
  } acrs_src_e;
endpackage

// ### src/acrs_div_if.sv
// interface: divider code and conversion clock enable between top and divider
`timescale 1ns/1ps
`default_nettype none
interface acrs_div_if;
  logic [5:0] code;
  logic tick;
  logic level;
  modport ctrl (output code, input tick, input level);
  modport div (input code, output tick, output level);
endinterface
`default_nettype wire

// ### src/acrs_clk_div.sv
// module: programmable divider making the conversion clock from the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module acrs_clk_div (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  acrs_div_if.div div_if
);
  logic [5:0] cnt_q;
  logic level_q;
  logic tick_q;

  // half period count
  // each half period lasts code+1 oscillator cycles, so a full period is 2*(code+1)
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 6'h00;
      level_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (cnt_q >= div_if.code) begin
      cnt_q <= 6'h00;
      level_q <= ~level_q;
      tick_q <= ~level_q;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

  assign div_if.tick = tick_q;
  assign div_if.level = level_q;

  div_period_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (cnt_q == div_if.code) |=> (level_q != $past(level_q) && cnt_q == 6'h00))
    else $error("conversion clock half period wrong");
  div_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (cnt_q < div_if.code) |=> $stable(level_q))
    else $error("conversion clock toggled early");
  div_max_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cnt_q <= div_if.code || $changed(div_if.code))
    else $error("divider counter out of range");
  div_tick_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    tick_q |-> (level_q && !$past(level_q)))
    else $error("conversion tick not on rising clock");
  div_slow_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) div_if.code == 6'h3f && tick_q);
endmodule
`default_nettype wire

// ### src/acrs_top.sv
// module: ahb-lite register block for converter clock divider, reference and channel select
// Operation
// - the conversion clock is the oscillator clock divided by twice the sum of the divider code and one.
// - the negative reference bit at bit 4 picks the reference pin when one and analog ground when zero.
// - the two positive reference bits pick the fixed buffer (11), the pin (10) or the supply (00).
// - unimplemented reference bits 7-5 and 3-2 read as zero and ignore writes.
// - every select field clears to zero on any reset and stays readable and writable.
// - a six bit channel field in bits 5-0 picks the source of the positive converter input.
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module acrs_top (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic conv_clk_o,
  output logic conv_tick_o,
  output logic nref_pin_sel_o,
  output logic nref_ground_sel_o,
  output logic pref_supply_sel_o,
  output logic pref_pin_sel_o,
  output logic pref_fixed_sel_o,
  output logic pref_reserved_o,
  output logic [5:0] chan_pin_o,
  output logic chan_pin_en_o,
  output logic [2:0] chan_src_o
);
  logic [7:0] clk_div_q;
  logic [7:0] ref_sel_q;
  logic [7:0] pch_sel_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic addr_ok;
  logic [7:0] ref_sel_d;
  acrs_div_if div_bus ();

  // address phase accepted when selected, ready and a real transfer
  assign addr_ok = hsel_i && hready_i && (htrans_i == acrs_pkg::HTRANS_NONSEQ || htrans_i == 2'h3);

  // zero wait state slave with always OKAY answer
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;

  // capture a write address so data can be taken in the next cycle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite_i;
      wr_addr_q <= haddr_i[11:0];
    end
  end

  assign ref_sel_d = hwdata_i[7:0] & acrs_pkg::REF_SEL_MASK;

  // registers clear then take writes
  // only the low byte lane matters; upper bits are not stored
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      clk_div_q <= acrs_pkg::CLK_DIV_RESET;
      ref_sel_q <= acrs_pkg::REF_SEL_RESET;
      pch_sel_q <= acrs_pkg::PCH_SEL_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        acrs_pkg::CLK_DIV_OFFSET: begin
          clk_div_q <= {2'h0, hwdata_i[5:0]};
        end
        acrs_pkg::REF_SEL_OFFSET: begin
          ref_sel_q <= ref_sel_d;
        end
        acrs_pkg::PCH_SEL_OFFSET: begin
          pch_sel_q <= {2'h0, hwdata_i[5:0]};
        end
        default: begin
          clk_div_q <= clk_div_q;
        end
      endcase
    end
  end

  // read data registered at the address phase; unmapped reads give zero
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      case (haddr_i[11:0])
        acrs_pkg::CLK_DIV_OFFSET: begin
          rdata_q <= {24'h000000, clk_div_q};
        end
        acrs_pkg::REF_SEL_OFFSET: begin
          rdata_q <= {24'h000000, ref_sel_q};
        end
        acrs_pkg::PCH_SEL_OFFSET: begin
          rdata_q <= {24'h000000, pch_sel_q};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // divider fed by the code field
  assign div_bus.code = clk_div_q[5:0];
  acrs_clk_div u_div (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .div_if(div_bus)
  );
  assign conv_clk_o = div_bus.level;
  assign conv_tick_o = div_bus.tick;

  assign nref_pin_sel_o = ref_sel_q[acrs_pkg::NREF_BIT];
  assign nref_ground_sel_o = ~ref_sel_q[acrs_pkg::NREF_BIT];

  assign pref_supply_sel_o = ref_sel_q[1:0] == acrs_pkg::PREF_SUPPLY;
  assign pref_pin_sel_o = ref_sel_q[1:0] == acrs_pkg::PREF_PIN;
  assign pref_fixed_sel_o = ref_sel_q[1:0] == acrs_pkg::PREF_FIXED;
  assign pref_reserved_o = ref_sel_q[1:0] == acrs_pkg::PREF_RESERVED;

  // channel field drives the analog mux
  assign chan_pin_o = pch_sel_q[5:0];

  always_comb begin
    chan_src_o = acrs_pkg::ACRS_SRC_PIN;
    case (pch_sel_q[5:0])
      acrs_pkg::CHAN_FIXED_REF: chan_src_o = acrs_pkg::ACRS_SRC_FIXED;
      acrs_pkg::CHAN_DAC: chan_src_o = acrs_pkg::ACRS_SRC_DAC;
      acrs_pkg::CHAN_TEMP: chan_src_o = acrs_pkg::ACRS_SRC_TEMP;
      acrs_pkg::CHAN_GROUND: chan_src_o = acrs_pkg::ACRS_SRC_GROUND;
      acrs_pkg::CHAN_NONE: chan_src_o = acrs_pkg::ACRS_SRC_NONE;
      default: chan_src_o = acrs_pkg::ACRS_SRC_PIN;
    endcase
  end
  assign chan_pin_en_o = chan_src_o == acrs_pkg::ACRS_SRC_PIN;

  // write then read back of reference register shows only implemented bits
  ref_mask_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (ref_sel_q & ~acrs_pkg::REF_SEL_MASK) == 8'h00)
    else $error("unimplemented reference bits set");
  ref_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (wr_pend_q && wr_addr_q == acrs_pkg::REF_SEL_OFFSET) |=> ref_sel_q == (8'($past(hwdata_i)) & 8'h13))
    else $error("reference register write lost");
  clk_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (wr_pend_q && wr_addr_q == acrs_pkg::CLK_DIV_OFFSET) |=> clk_div_q == {2'h0, 6'($past(hwdata_i))})
    else $error("clock divider write lost");
  reset_clear_a: assert property (@(posedge sys_clk_i)
    !resetn_i |=> (clk_div_q == 8'h00 && ref_sel_q == 8'h00 && pch_sel_q == 8'h00))
    else $error("select fields not cleared by reset");
  nref_route_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    nref_pin_sel_o != nref_ground_sel_o && nref_pin_sel_o == ref_sel_q[4])
    else $error("negative reference routing wrong");
  pref_onehot_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $onehot({pref_supply_sel_o, pref_pin_sel_o, pref_fixed_sel_o, pref_reserved_o}))
    else $error("positive reference select not one hot");
  chan_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_ok && !hwrite_i && haddr_i[11:0] == acrs_pkg::PCH_SEL_OFFSET && !wr_pend_q)
      |=> hrdata_o == {26'h0, 6'($past(pch_sel_q))})
    else $error("channel readback wrong");
  chan_none_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pch_sel_q[5:0] == 6'h3b) |-> (!chan_pin_en_o && chan_src_o == acrs_pkg::ACRS_SRC_NONE))
    else $error("unconnected channel code routes a pin");
  pref_fixed_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) pref_fixed_sel_o && nref_pin_sel_o);
  chan_temp_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) chan_src_o == acrs_pkg::ACRS_SRC_TEMP);
  read_ref_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    addr_ok && !hwrite_i && haddr_i[11:0] == acrs_pkg::REF_SEL_OFFSET);
  write_chan_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr_pend_q && wr_addr_q == acrs_pkg::PCH_SEL_OFFSET);

  // writes land only in the addressed register
  pch_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (wr_pend_q && wr_addr_q == acrs_pkg::PCH_SEL_OFFSET) |=> pch_sel_q == {2'h0, 6'($past(hwdata_i))})
    else $error("channel register write lost");
  stray_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (wr_pend_q && wr_addr_q != acrs_pkg::CLK_DIV_OFFSET && wr_addr_q != acrs_pkg::REF_SEL_OFFSET
      && wr_addr_q != acrs_pkg::PCH_SEL_OFFSET)
      |=> ($stable(clk_div_q) && $stable(ref_sel_q) && $stable(pch_sel_q)))
    else $error("unmapped write changed a register");
  // read data: upper lanes and unimplemented bits always zero
  read_high_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hrdata_o[31:8] == 24'h000000)
    else $error("read data above the byte lane not zero");
  ref_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_ok && !hwrite_i && haddr_i[11:0] == acrs_pkg::REF_SEL_OFFSET)
      |=> hrdata_o == {24'h000000, $past(ref_sel_q) & 8'h13})
    else $error("reference readback wrong");
  clk_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (addr_ok && !hwrite_i && haddr_i[11:0] == acrs_pkg::CLK_DIV_OFFSET)
      |=> hrdata_o == {26'h0, 6'($past(clk_div_q))})
    else $error("clock divider readback wrong");
  // decodes follow the stored codes
  pref_decode_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pref_fixed_sel_o == (ref_sel_q[1:0] == 2'h3) && pref_pin_sel_o == (ref_sel_q[1:0] == 2'h2)
      && pref_supply_sel_o == (ref_sel_q[1:0] == 2'h0))
    else $error("positive reference decode wrong");
  chan_inner_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pch_sel_q[5:0] > 6'h3b) |-> (!chan_pin_en_o && chan_src_o > 3'h1))
    else $error("internal channel code routes a pin");
  chan_pin_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pch_sel_q[5:0] < 6'h3b) |-> (chan_pin_en_o && chan_src_o == 3'h0 && chan_pin_o == pch_sel_q[5:0]))
    else $error("external channel code not routed");
  // conversion clock outputs quiet in reset, tick one cycle wide
  conv_reset_a: assert property (@(posedge sys_clk_i)
    !resetn_i |=> (!conv_clk_o && !conv_tick_o && hrdata_o == 32'h0000_0000))
    else $error("outputs not cleared by reset");
  tick_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    conv_tick_o |=> !conv_tick_o)
    else $error("conversion tick wider than one cycle");
endmodule
`default_nettype wire

// ### testbench/acrs_core_model.sv
// partner model: converter core and reference multiplexers
`timescale 1ns/1ps
`default_nettype none
module acrs_core_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic conv_tick_i,
  input wire logic pref_supply_i,
  input wire logic pref_pin_i,
  input wire logic pref_fixed_i,
  output logic [7:0] period_o,
  output logic [7:0] ticks_o,
  output logic [1:0] pref_hot_o
);
  logic [7:0] cnt_q;
  // conversion clock period
  // core times its clock between ticks; 8 bits hold the longest period
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 8'h00;
      period_o <= 8'h00;
      ticks_o <= 8'h00;
    end else if (conv_tick_i) begin
      period_o <= cnt_q + 8'h01;
      cnt_q <= 8'h00;
      ticks_o <= ticks_o + 8'h01;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // reference mux paths
  // the reserved code closes no path, so the count drops to zero
  assign pref_hot_o = 2'(pref_supply_i) + 2'(pref_pin_i) + 2'(pref_fixed_i);
endmodule
`default_nettype wire

// ### testbench/adc_clock_ref_select_tb_top.sv
// testbench: register access, select decodes and divider period
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module adc_clock_ref_select_tb_top;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r;} acrs_row_s;
  logic sys_clk, resetn, hsel, hwrite, hready, hresp, cclk, tick;
  logic nref_pin, nref_gnd, p_sup, p_pin, p_fix, p_res, chan_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hot;
  logic [2:0] hsize, chan_src;
  logic [5:0] chan_pin;
  logic [7:0] period, ticks, t0;
  int fail_count = 0;
  int total_checks = 0;
  int wait_n = 0;
  acrs_row_s rows [8] = '{'{0, 12'h000, 0, 0}, '{0, 12'h004, 0, 0}, '{0, 12'h008, 0, 0},
    '{1, 12'h000, 32'hffffffff, 32'h3f}, '{1, 12'h004, 32'hffffffff, 32'h13},
    '{1, 12'h008, 32'hffffffff, 32'h3f}, '{1, 12'h00c, 32'hffffffff, 0}, '{1, 12'h004, 32'h12, 32'h12}};
  logic [5:0] ch [6] = '{6'h00, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
  logic [5:0] dv [3] = '{6'h00, 6'h05, 6'h3f};
  acrs_top DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .conv_clk_o(cclk), .conv_tick_o(tick), .nref_pin_sel_o(nref_pin),
    .nref_ground_sel_o(nref_gnd), .pref_supply_sel_o(p_sup), .pref_pin_sel_o(p_pin), .pref_fixed_sel_o(p_fix),
    .pref_reserved_o(p_res), .chan_pin_o(chan_pin), .chan_pin_en_o(chan_en), .chan_src_o(chan_src));
  acrs_core_model model (.sys_clk_i(sys_clk), .resetn_i(resetn), .conv_tick_i(tick), .pref_supply_i(p_sup),
    .pref_pin_i(p_pin), .pref_fixed_i(p_fix), .period_o(period), .ticks_o(ticks), .pref_hot_o(hot));
  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // bounded wait for the slave's ready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask
  // one single-word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= acrs_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {resetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    `CHK(nref_gnd, 1'b1)
    `CHK(p_sup, 1'b1)
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].r)
    end
    `CHK(hresp, 1'b0)
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, acrs_pkg::REF_SEL_OFFSET, {27'h0, c[0], 2'h0, c[1:0]});
      @(posedge sys_clk);
      `CHK(nref_pin, c[0])
      `CHK(nref_gnd, ~c[0])
      `CHK({p_fix, p_pin, p_sup}, {c == 3, c == 2, c == 0})
      `CHK(p_res, c == 1)
      `CHK(hot, (c == 1) ? 2'h0 : 2'h1)
    end
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, acrs_pkg::PCH_SEL_OFFSET, {26'h0, ch[i]});
      @(posedge sys_clk);
      `CHK(chan_pin, ch[i])
      `CHK(chan_src, 3'(i))
      `CHK(chan_en, i == 0)
    end
    // divider: let three ticks pass so the last interval is fully at the new code
    foreach (dv[i]) begin
      xfer(1'b1, acrs_pkg::CLK_DIV_OFFSET, {26'h0, dv[i]});
      t0 = ticks;
      wait_n = 0;
      while (8'(ticks - t0) < 8'h03 && wait_n < 1000) begin
        @(posedge sys_clk);
        wait_n++;
      end
      if (8'(ticks - t0) < 8'h03) begin
        fail_count++;
        test_done();
      end
      `CHK(period, 8'(2 * (dv[i] + 1)))
    end
    // reset in mid-run clears everything again
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(cclk, 1'b0)
    `CHK(tick, 1'b0)
    `CHK(hrdata, 32'h0)
    resetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      xfer(1'b0, 12'(4 * k), 32'h0);
      `CHK(rd, 32'h0)
    end
    `CHK(chan_src, 3'(acrs_pkg::ACRS_SRC_PIN))
    test_done();
  end
endmodule
`default_nettype wire
